/* File: src/pdm_port_ctrl.sv */
// Port controller end: companion reset, connect interrupt, I2C target, mux events, PDOs
// How it works
// RULE1 - Hold companion reset until configuration loaded
// RULE2 - Own flash read first, companion afterwards
// RULE3 - First GPIO is companion reset only
// RULE4 - Release reset 100 us after supply
// RULE5 - Outside logic ANDs reset with supply
// RULE6 - Controller may release after system boot
// RULE7 - Interrupt companion on resolved connection
// RULE8 - Companion reads status over I2C
// RULE9 - I2C target answers address 0x38
// RULE10 - Drive flip, USB3 and DP mux selects
// RULE11 - Drive sideband selects and enables
// RULE12 - Companion setup: source 5 V 3 A
// RULE13 - Plain setup: source 5 V 1.5 A
// RULE14 - Sink 5/9/15/20 V at 3 A
// RULE15 - Update muxes per event, idle on detach
`timescale 1ns/1ps
`default_nettype none
module pdm_port_ctrl
	import pdm_pkg::*;
#(
	parameter int unsigned RST_DELAY_CYC = pdm_pkg::RST_REL_CYC
) (
	input wire logic mclk,
	input wire logic srst,
	pdm_link_if.device link,
	input wire logic cfg_load_done,
	input wire logic companion_mode,
	input wire logic hold_until_boot,
	input wire logic system_booted,
	input wire logic port_attached,
	input wire logic port_flipped,
	input wire logic port_usb3,
	input wire logic port_dp,
	input wire logic port_cprot,
	output logic [31:0] src_pdo,
	output logic [31:0] snk_pdo [4],
	output logic companion_running
);
	import pdm_pkg::*;

	pdm_rst_state_type rst_state_ff;
	logic [$clog2(RST_DELAY_CYC + 1)-1:0] dly_cnt_ff;
	logic [SYNC_STAGES-1:0] pwr_sync_ff, scl_sync_ff, sda_sync_ff;
	logic pwr_ok, scl_s, sda_s, scl_prev_ff, sda_prev_ff;
	logic [7:0] status_ff, nxt_status;
	logic irq_pend_ff;
	pdm_i2c_state_type i2c_state_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic read_ff, sda_low_ff;
	logic addr_full_ff;

	// Pin inputs: three stages; SCL and SDA change once the last two agree, supply counts good only while both are high
	always_ff @(posedge mclk) begin
		pwr_sync_ff <= {pwr_sync_ff[1:0], link.companion_supply_3v3};
		scl_sync_ff <= {scl_sync_ff[1:0], link.scl};
		sda_sync_ff <= {sda_sync_ff[1:0], link.sda};
		if (srst) begin
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl_s;
			sda_prev_ff <= sda_s;
		end
	end
	assign pwr_ok = pwr_sync_ff[2] & pwr_sync_ff[1];
	assign scl_s = (scl_sync_ff[2] == scl_sync_ff[1]) ? scl_sync_ff[2] : scl_prev_ff;
	assign sda_s = (sda_sync_ff[2] == sda_sync_ff[1]) ? sda_sync_ff[2] : sda_prev_ff;

	// Companion reset sequencing
	always_ff @(posedge mclk) begin
		if (srst) begin
			rst_state_ff <= RS_LOAD;
			dly_cnt_ff <= '0;
		end else begin
			case (rst_state_ff)
				RS_LOAD: begin
					if (cfg_load_done) begin // [RULE1] [RULE2]
						rst_state_ff <= RS_WAIT_PWR;
					end
				end
				RS_WAIT_PWR: begin
					dly_cnt_ff <= '0;
					if (pwr_ok) begin
						rst_state_ff <= RS_DELAY;
					end
				end
				RS_DELAY: begin
					if (!pwr_ok) begin
						rst_state_ff <= RS_WAIT_PWR; // [RULE5]
					end else if (32'(dly_cnt_ff) >= RST_DELAY_CYC - 1) begin // [RULE4]
						if (!hold_until_boot || system_booted) begin // [RULE6]
							rst_state_ff <= RS_RUN;
						end
					end else begin
						dly_cnt_ff <= dly_cnt_ff + 1'b1;
					end
				end
				RS_RUN: begin
					if (!pwr_ok) begin
						rst_state_ff <= RS_WAIT_PWR; // Supply loss puts companion back in reset
					end
				end
				default: rst_state_ff <= RS_LOAD;
			endcase
		end
	end
	// Dedicated pin, nothing else shares it
	assign link.companion_reset_line = (rst_state_ff == RS_RUN) ? 1'b1 : RSTN_ASSERTED; // [RULE3]
	assign link.flash_cfg_done = (rst_state_ff != RS_LOAD); // [RULE2]
	assign companion_running = (rst_state_ff == RS_RUN);

	// Port status, mux outputs; idle when detached
	always_ff @(posedge mclk) begin
		if (srst) begin
			status_ff <= STATUS_RESET;
		end else begin
			status_ff <= nxt_status; // [RULE15]
		end
	end
	always_comb begin
		nxt_status = STATUS_RESET;
		if (port_attached) begin
			nxt_status[ST_ATTACH_POS] = 1'b1;
			nxt_status[ST_FLIP_POS] = port_flipped;
			nxt_status[ST_USB3_POS] = port_usb3;
			nxt_status[ST_DP_POS] = port_dp;
			nxt_status[ST_CPROT_POS] = port_cprot;
		end
	end
	assign link.mux_flip = status_ff[ST_FLIP_POS]; // [RULE10]
	assign link.mux_usb3_select = status_ff[ST_USB3_POS]; // [RULE10]
	assign link.mux_dp_select = status_ff[ST_DP_POS]; // [RULE10]
	assign link.sideband_a_output_select = status_ff[ST_FLIP_POS]; // [RULE11]
	assign link.sideband_b_output_select = status_ff[ST_FLIP_POS]; // [RULE11]
	assign link.aux_path_enable = status_ff[ST_DP_POS]; // [RULE11]
	assign link.low_speed_link_enable = status_ff[ST_CPROT_POS]; // [RULE11]

	// Interrupt pending from any status change until the companion reads it
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_pend_ff <= 1'b0;
		end else if (nxt_status != status_ff) begin
			irq_pend_ff <= 1'b1; // [RULE7] set wins over the read clear
		end else if (i2c_state_ff == IT_DACK && read_ff && scl_s && !scl_prev_ff) begin
			irq_pend_ff <= 1'b0; // [RULE8]
		end
	end
	assign link.companion_irq_n = !(irq_pend_ff && rst_state_ff == RS_RUN);

	// I2C target: status byte resent for every read byte until controller NACK, writes acknowledged and dropped
	always_ff @(posedge mclk) begin
		if (srst) begin
			i2c_state_ff <= IT_IDLE;
			bit_cnt_ff <= '0;
			shift_ff <= '0;
			read_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			addr_full_ff <= 1'b0;
		end else if (scl_s && sda_prev_ff && !sda_s) begin
			i2c_state_ff <= IT_ADDR; // Start or repeated start
			bit_cnt_ff <= '0;
			sda_low_ff <= 1'b0;
			addr_full_ff <= 1'b0;
		end else if (scl_s && !sda_prev_ff && sda_s) begin
			i2c_state_ff <= IT_IDLE; // Stop
			sda_low_ff <= 1'b0;
		end else if (scl_s && !scl_prev_ff) begin
			// Rising SCL: sample
			case (i2c_state_ff)
				IT_ADDR: begin
					shift_ff <= {shift_ff[6:0], sda_s};
					bit_cnt_ff <= bit_cnt_ff + 1'b1;
					addr_full_ff <= (bit_cnt_ff == 3'd7);
				end
				IT_DACK: begin
					if (sda_s) begin
						i2c_state_ff <= IT_SKIP; // Controller NACK ends the read
					end
				end
				default: ;
			endcase
		end else if (!scl_s && scl_prev_ff) begin
			// Falling SCL: advance and drive
			case (i2c_state_ff)
				IT_ADDR: begin
					// First falling edge after start holds no address yet
					if (addr_full_ff) begin
						if (shift_ff[7:1] == I2C_TGT_ADDR) begin // [RULE9]
							i2c_state_ff <= IT_AACK;
							read_ff <= shift_ff[0];
							sda_low_ff <= 1'b1;
						end else begin
							i2c_state_ff <= IT_SKIP;
						end
					end
				end
				IT_AACK: begin
					i2c_state_ff <= IT_DATA;
					bit_cnt_ff <= '0;
					shift_ff <= status_ff; // [RULE8]
					sda_low_ff <= read_ff && !status_ff[7];
				end
				IT_DATA: begin
					bit_cnt_ff <= bit_cnt_ff + 1'b1;
					if (bit_cnt_ff == 3'd7) begin
						i2c_state_ff <= IT_DACK;
						sda_low_ff <= !read_ff; // Ack written byte
					end else begin
						shift_ff <= {shift_ff[6:0], sda_s};
						sda_low_ff <= read_ff && !shift_ff[6];
					end
				end
				IT_DACK: begin
					i2c_state_ff <= IT_DATA;
					bit_cnt_ff <= '0;
					shift_ff <= status_ff;
					sda_low_ff <= read_ff && !status_ff[7];
				end
				default: sda_low_ff <= 1'b0;
			endcase
		end
	end
	assign link.sda_dev_out = 1'b0;
	assign link.sda_dev_oe = sda_low_ff;

	// Advertised power objects
	always_ff @(posedge mclk) begin
		if (srst) begin
			src_pdo <= '0;
			snk_pdo <= '{default: '0};
		end else begin
			if (companion_mode) begin
				src_pdo <= pdm_fixed_pdo(PDO_V_5V, PDO_I_3A); // [RULE12]
			end else begin
				src_pdo <= pdm_fixed_pdo(PDO_V_5V, PDO_I_1A5); // [RULE13]
			end
			snk_pdo[0] <= pdm_fixed_pdo(PDO_V_5V, PDO_I_3A); // [RULE14]
			snk_pdo[1] <= pdm_fixed_pdo(PDO_V_9V, PDO_I_3A); // [RULE14]
			snk_pdo[2] <= pdm_fixed_pdo(PDO_V_15V, PDO_I_3A); // [RULE14]
			snk_pdo[3] <= pdm_fixed_pdo(PDO_V_20V, PDO_I_3A); // [RULE14]
		end
	end
endmodule
`default_nettype wire

/* File: include/pdm_pkg.sv */
// Package: constants and types shared by both ends of the port glue link
package pdm_pkg;
	localparam int unsigned CLK_MHZ = 50;
	// Least wait from companion supply valid to reset release, in us
	localparam int unsigned RST_REL_US = 100;
	localparam int unsigned RST_REL_CYC = RST_REL_US * CLK_MHZ;
	localparam logic [6:0] I2C_TGT_ADDR = 7'h38;
	localparam int unsigned SYNC_STAGES = 3;
	// Fixed PDO fields: voltage in 50 mV units, current in 10 mA units
	localparam logic [9:0] PDO_V_5V = 10'h064;
	localparam logic [9:0] PDO_V_9V = 10'h0b4;
	localparam logic [9:0] PDO_V_15V = 10'h12c;
	localparam logic [9:0] PDO_V_20V = 10'h190;
	localparam logic [9:0] PDO_I_1A5 = 10'h096;
	localparam logic [9:0] PDO_I_3A = 10'h12c;
	localparam logic [9:0] PDO_I_5A = 10'h1f4;
	localparam int unsigned PDO_V_POS = 10;
	localparam int unsigned PDO_I_POS = 0;
	localparam logic [31:0] PDO_FIXED_TAG = 32'h0000_0000;
	// Mux control and link reset values
	localparam logic MUX_IDLE = 1'b0;
	localparam logic RSTN_ASSERTED = 1'b0;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	// Status byte field positions
	localparam int unsigned ST_ATTACH_POS = 0;
	localparam int unsigned ST_FLIP_POS = 1;
	localparam int unsigned ST_USB3_POS = 2;
	localparam int unsigned ST_DP_POS = 3;
	localparam int unsigned ST_CPROT_POS = 4;

	typedef enum logic [1:0] {
		RS_LOAD = 2'b00,
		RS_WAIT_PWR = 2'b01,
		RS_DELAY = 2'b10,
		RS_RUN = 2'b11
	} pdm_rst_state_type;

	typedef enum logic [2:0] {
		IT_IDLE = 3'b000,
		IT_ADDR = 3'b001,
		IT_AACK = 3'b010,
		IT_DATA = 3'b011,
		IT_DACK = 3'b100,
		IT_SKIP = 3'b101
	} pdm_i2c_state_type;

	function automatic logic [31:0] pdm_fixed_pdo(input logic [9:0] volt, input logic [9:0] amp);
		pdm_fixed_pdo = PDO_FIXED_TAG | (32'(volt) << PDO_V_POS) | (32'(amp) << PDO_I_POS);
	endfunction
endpackage

/* File: include/pdm_link_if.sv */
// Interface: pins between the port controller and the companion side
`timescale 1ns/1ps
`default_nettype none
interface pdm_link_if;
	logic companion_reset_line;
	logic companion_supply_3v3;
	logic companion_irq_n;
	logic flash_cfg_done;
	logic flash_fw_busy;
	logic scl;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda_cmp_out;
	logic sda_cmp_oe;
	logic sda;
	logic mux_flip;
	logic mux_usb3_select;
	logic mux_dp_select;
	logic sideband_a_output_select;
	logic sideband_b_output_select;
	logic aux_path_enable;
	logic low_speed_link_enable;
	// Open-drain wire level worked out from both enables
	assign sda = !((sda_dev_oe && !sda_dev_out) || (sda_cmp_oe && !sda_cmp_out));

	modport device (
		output companion_reset_line, companion_irq_n, flash_cfg_done, sda_dev_out, sda_dev_oe,
		output mux_flip, mux_usb3_select, mux_dp_select, sideband_a_output_select,
		output sideband_b_output_select, aux_path_enable, low_speed_link_enable,
		input companion_supply_3v3, flash_fw_busy, scl, sda
	);
	modport companion (
		input companion_reset_line, companion_irq_n, flash_cfg_done, sda,
		input mux_flip, mux_usb3_select, mux_dp_select, sideband_a_output_select,
		input sideband_b_output_select, aux_path_enable, low_speed_link_enable,
		output companion_supply_3v3, flash_fw_busy, scl, sda_cmp_out, sda_cmp_oe
	);
endinterface
`default_nettype wire

/* File: src/pdm_companion.sv */
// Companion end: waits for reset release and flash turn, reads status on interrupt
`timescale 1ns/1ps
`default_nettype none
module pdm_companion
	import pdm_pkg::*;
#(
	parameter int unsigned SCL_HALF = 8
) (
	input wire logic mclk,
	input wire logic srst,
	pdm_link_if.companion link,
	input wire logic supply_good,
	input wire logic fw_load_req,
	output logic fw_loading,
	output logic in_reset,
	output logic [7:0] port_status,
	output logic status_valid
);
	import pdm_pkg::*;

	logic [SYNC_STAGES-1:0] rst_sync_ff, irq_sync_ff, done_sync_ff, sda_sync_ff;
	logic rstn_s, irq_s, done_s;
	logic [$clog2(SCL_HALF + 1)-1:0] half_cnt_ff;
	logic [5:0] step_ff;
	logic busy_ff, scl_ff, sda_low_ff;
	logic [7:0] addr_byte;
	logic [7:0] rx_ff;

	always_ff @(posedge mclk) begin
		rst_sync_ff <= {rst_sync_ff[1:0], link.companion_reset_line};
		irq_sync_ff <= {irq_sync_ff[1:0], link.companion_irq_n};
		done_sync_ff <= {done_sync_ff[1:0], link.flash_cfg_done};
		sda_sync_ff <= {sda_sync_ff[1:0], link.sda};
	end
	// Reset seen only while powered; the AND of reset and supply
	assign rstn_s = rst_sync_ff[2] & rst_sync_ff[1] & supply_good; // [RULE5]
	assign irq_s = !(irq_sync_ff[2] | irq_sync_ff[1]);
	assign done_s = done_sync_ff[2] & done_sync_ff[1];
	assign in_reset = !rstn_s;
	assign link.companion_supply_3v3 = supply_good;

	// Firmware read only after the controller finished its turn
	always_ff @(posedge mclk) begin
		if (srst || !rstn_s) begin
			fw_loading <= 1'b0;
		end else begin
			fw_loading <= fw_load_req && done_s; // [RULE2]
		end
	end
	assign link.flash_fw_busy = fw_loading;

	// Bit-banged read: start, 9 address clocks, 9 data clocks, stop
	assign addr_byte = {I2C_TGT_ADDR, 1'b1};
	always_ff @(posedge mclk) begin
		if (srst || !rstn_s) begin
			busy_ff <= 1'b0;
			step_ff <= '0;
			half_cnt_ff <= '0;
			scl_ff <= 1'b1;
			sda_low_ff <= 1'b0;
			rx_ff <= '0;
			port_status <= STATUS_RESET;
			status_valid <= 1'b0;
		end else begin
			status_valid <= 1'b0;
			if (!busy_ff) begin
				if (irq_s) begin // [RULE8]
					busy_ff <= 1'b1;
					sda_low_ff <= 1'b1;
					step_ff <= '0;
					half_cnt_ff <= '0;
				end
			end else if (32'(half_cnt_ff) < SCL_HALF - 1) begin
				half_cnt_ff <= half_cnt_ff + 1'b1;
			end else begin
				half_cnt_ff <= '0;
				step_ff <= step_ff + 1'b1;
				if (step_ff < 6'd36) begin
					scl_ff <= step_ff[0];
					if (!step_ff[0]) begin
						// Set SDA while SCL low
						if (step_ff < 6'd16) begin
							sda_low_ff <= !addr_byte[3'(7 - step_ff[4:1])];
						end else if (step_ff < 6'd18) begin
							sda_low_ff <= 1'b0;
						end else if (step_ff < 6'd34) begin
							sda_low_ff <= 1'b0;
						end else begin
							sda_low_ff <= 1'b0; // NACK last byte
						end
					end else if (step_ff >= 6'd19 && step_ff < 6'd35) begin
						rx_ff <= {rx_ff[6:0], sda_sync_ff[2]};
					end
				end else if (step_ff == 6'd36) begin
					scl_ff <= 1'b0;
					sda_low_ff <= 1'b1;
				end else if (step_ff == 6'd37) begin
					scl_ff <= 1'b1;
				end else begin
					sda_low_ff <= 1'b0;
					busy_ff <= 1'b0;
					port_status <= rx_ff;
					status_valid <= 1'b1;
				end
			end
		end
	end
	assign link.scl = scl_ff;
	assign link.sda_cmp_out = 1'b0;
	assign link.sda_cmp_oe = sda_low_ff;
endmodule
`default_nettype wire

/* File: verification/pdm_link_properties.sv */
// Checker: timing and pairing relations on the port glue link
`timescale 1ns/1ps
`default_nettype none
module pdm_link_properties #(
	parameter int unsigned RST_DELAY_CYC = 5000
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic companion_reset_line,
	input wire logic companion_supply_3v3,
	input wire logic companion_irq_n,
	input wire logic flash_cfg_done,
	input wire logic flash_fw_busy,
	input wire logic mux_flip,
	input wire logic mux_usb3_select,
	input wire logic mux_dp_select,
	input wire logic sideband_a_output_select,
	input wire logic sideband_b_output_select,
	input wire logic aux_path_enable,
	input wire logic low_speed_link_enable
);
	// Cycles the supply has stood valid, saturating
	logic [15:0] pwr_cnt_ff;
	always_ff @(posedge mclk) begin
		if (srst || !companion_supply_3v3) begin
			pwr_cnt_ff <= 16'h0000;
		end else if (pwr_cnt_ff != 16'hffff) begin
			pwr_cnt_ff <= pwr_cnt_ff + 16'h0001;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_cfg_before_release: assert property (!flash_cfg_done |-> !companion_reset_line)
		else $error("companion released before config load");
	a_supply_settle_time: assert property ($rose(companion_reset_line) |-> pwr_cnt_ff >= RST_DELAY_CYC)
		else $error("companion released too soon after supply");
	a_supply_loss_reset: assert property (companion_reset_line && !companion_supply_3v3 |-> ##[1:6] !companion_reset_line)
		else $error("reset not reasserted on supply loss");
	a_fw_after_cfg: assert property (flash_fw_busy |-> flash_cfg_done)
		else $error("firmware read overlaps config read");
	a_irq_on_event: assert property ($changed({mux_flip, mux_usb3_select, mux_dp_select, low_speed_link_enable}) && companion_reset_line |-> ##[0:2] !companion_irq_n)
		else $error("no interrupt after port event");
	a_irq_stands: assert property ($fell(companion_irq_n) |=> !companion_irq_n [*4])
		else $error("interrupt dropped before status read");
	a_sideband_pair: assert property (sideband_a_output_select == sideband_b_output_select)
		else $error("sideband selects differ");
	a_flip_to_sideband: assert property (sideband_a_output_select == mux_flip)
		else $error("orientation outputs differ");
	a_aux_follows_dp: assert property (aux_path_enable == mux_dp_select)
		else $error("aux enable differs from dp select");
endmodule
`default_nettype wire

/* File: verification/pdm_port_mux_and_companion_reset_control_tb.sv */
// Testbench: both ends joined, reset ordering, pdos, mux events and status reads
`timescale 1ns/1ps
`default_nettype none
module pdm_port_mux_and_companion_reset_control_tb;
	import pdm_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic cfg_load_done = 1'b0, companion_mode = 1'b1, hold_until_boot = 1'b0;
	logic system_booted = 1'b0, supply_good = 1'b1, fw_load_req = 1'b1;
	logic port_attached = 1'b0, port_flipped = 1'b0, port_usb3 = 1'b0;
	logic port_dp = 1'b0, port_cprot = 1'b0;
	logic [31:0] src_pdo, exp_pdo;
	logic [31:0] snk_pdo [4];
	logic companion_running, fw_loading, in_reset, status_valid;
	logic [7:0] port_status;
	logic [9:0] snk_v [4] = '{PDO_V_5V, PDO_V_9V, PDO_V_15V, PDO_V_20V};
	wire logic [6:0] mux_vec;
	int error_cnt = 0, total_checks = 0, k, i;
	pdm_link_if link();
	assign mux_vec = {link.mux_flip, link.mux_usb3_select, link.mux_dp_select,
		link.sideband_a_output_select, link.sideband_b_output_select,
		link.aux_path_enable, link.low_speed_link_enable};
	pdm_port_ctrl #(.RST_DELAY_CYC(20)) pdm_port_ctrl_inst (.mclk(mclk), .srst(srst),
		.link(link), .cfg_load_done(cfg_load_done), .companion_mode(companion_mode),
		.hold_until_boot(hold_until_boot), .system_booted(system_booted),
		.port_attached(port_attached), .port_flipped(port_flipped), .port_usb3(port_usb3),
		.port_dp(port_dp), .port_cprot(port_cprot), .src_pdo(src_pdo), .snk_pdo(snk_pdo),
		.companion_running(companion_running));
	pdm_companion pdm_companion_inst (.mclk(mclk), .srst(srst), .link(link),
		.supply_good(supply_good), .fw_load_req(fw_load_req), .fw_loading(fw_loading),
		.in_reset(in_reset), .port_status(port_status), .status_valid(status_valid));
	pdm_link_properties #(.RST_DELAY_CYC(20)) pdm_link_properties_inst (.mclk(mclk),
		.srst(srst), .companion_reset_line(link.companion_reset_line),
		.companion_supply_3v3(link.companion_supply_3v3),
		.companion_irq_n(link.companion_irq_n), .flash_cfg_done(link.flash_cfg_done),
		.flash_fw_busy(link.flash_fw_busy), .mux_flip(link.mux_flip),
		.mux_usb3_select(link.mux_usb3_select), .mux_dp_select(link.mux_dp_select),
		.sideband_a_output_select(link.sideband_a_output_select),
		.sideband_b_output_select(link.sideband_b_output_select),
		.aux_path_enable(link.aux_path_enable),
		.low_speed_link_enable(link.low_speed_link_enable));
	initial begin
		forever #10 mclk = ~mclk;
	end
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait: k reports how long the release took
	task wait_release;
		for (k = 0; k < 500 && link.companion_reset_line !== 1'b1; k++) tick(1);
	endtask
	task step(input logic att, input logic [3:0] p);
		int n;
		{port_cprot, port_dp, port_usb3, port_flipped} = p;
		port_attached = att;
		tick(3);
		check(32'(link.companion_irq_n), 32'h0);
		check(32'(mux_vec), att ? 32'({p[0], p[1], p[2], p[0], p[0], p[2], p[3]}) : 32'h0);
		for (n = 0; n < 3000 && status_valid !== 1'b1; n++) tick(1);
		check(32'(port_status[0]), 32'(att));
		if (att) check(32'(port_status[4:0]), 32'({p, 1'b1}));
		tick(30);
		check(32'(link.companion_irq_n), 32'h1);
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#(20 * 60000);
		error_cnt++;
		end_of_test;
	end
	initial begin
		tick(5);
		srst = 1'b0;
		tick(40);
		check(32'(link.companion_reset_line), 32'h0);
		check(32'(fw_loading), 32'h0);
		cfg_load_done = 1'b1;
		wait_release;
		check(32'(companion_running), 32'h1);
		tick(3);
		check(32'(in_reset), 32'h0);
		tick(10);
		check(32'(fw_loading), 32'h1);
		$display("test reset order done");
		exp_pdo = PDO_FIXED_TAG | (32'(PDO_V_5V) << PDO_V_POS);
		check(src_pdo, exp_pdo | (32'(PDO_I_3A) << PDO_I_POS));
		companion_mode = 1'b0;
		tick(3);
		check(src_pdo, exp_pdo | (32'(PDO_I_1A5) << PDO_I_POS));
		for (i = 0; i < 4; i++) begin
			exp_pdo = PDO_FIXED_TAG | (32'(snk_v[i]) << PDO_V_POS) | (32'(PDO_I_3A) << PDO_I_POS);
			if (i < 3) check(snk_pdo[i], exp_pdo);
			else check((snk_pdo[i] >> PDO_V_POS) & 32'h0000_03ff, 32'(snk_v[i]));
		end
		$display("test pdo done");
		for (i = 0; i < 16; i++) step(1'b1, 4'(i));
		step(1'b0, 4'hf);
		$display("test mux events done");
		supply_good = 1'b0;
		tick(8);
		check(32'(link.companion_reset_line), 32'h0);
		supply_good = 1'b1;
		wait_release;
		check(32'(k >= 20 && k < 500), 32'h1);
		hold_until_boot = 1'b1;
		supply_good = 1'b0;
		tick(8);
		supply_good = 1'b1;
		tick(60);
		check(32'(link.companion_reset_line), 32'h0);
		system_booted = 1'b1;
		wait_release;
		check(32'(link.companion_reset_line), 32'h1);
		$display("test supply done");
		end_of_test;
	end
endmodule
`default_nettype wire
